//--- gotr_buffer_model.sv
`timescale 1ns/1ps
module gotr_buffer_model
(
  // clock
  input  wire logic        i_clk_sys,
  // flag requests from the bench
  input  wire logic        i_warn_req,
  input  wire logic        i_err_req,
  // toward the block
  output logic      [15:0] o_sample = 16'h0000,
  output logic             o_warning,
  output logic             o_error
);
  integer seed = 72076; // fixed seed keeps runs repeatable
  // flags follow the bench so cutoffs happen only when a test wants one
  assign o_warning = i_warn_req;
  assign o_error   = i_err_req;
  // fresh sample every cycle, changed away from the sampling edge
  always @(negedge i_clk_sys)
    o_sample <= 16'($random(seed));
endmodule : gotr_buffer_model

//--- gotr_pkg.sv
package gotr_pkg;

  // register addresses on the serial-port register space
  localparam logic [7:0] ADDR_PATH_CTRL      = 8'h27;
  localparam logic [7:0] ADDR_OFFSET_LOW     = 8'h3b;
  localparam logic [7:0] ADDR_OFFSET_HIGH    = 8'h3c;
  localparam logic [7:0] ADDR_DIGITAL_GAIN   = 8'h3f;
  localparam logic [7:0] ADDR_RISE_STEP      = 8'h41;
  localparam logic [7:0] ADDR_FALL_STEP      = 8'h42;
  localparam logic [7:0] ADDR_GATE_CTRL      = 8'h43;
  localparam logic [7:0] ADDR_SHUTDOWN_CTRL  = 8'h44;

  // field positions
  localparam int BIT_PATH_ENABLE      = 5;
  localparam int BIT_OUTPUT_STATUS    = 7;
  localparam int BIT_OUTPUT_RESTORE   = 6;
  localparam int BIT_RAMP_ENABLE      = 2;
  localparam int BIT_SLEEP_ENABLE     = 1;
  localparam int BIT_POWERDOWN_ENABLE = 0;
  localparam int BIT_CUTOFF_MASTER    = 7;
  localparam int BIT_WARNING_CUTOFF   = 3;
  localparam int BIT_ERROR_CUTOFF     = 0;

  // widths
  localparam int GAIN_W   = 6;
  localparam int SAMPLE_W = 16;
  localparam int FRAC_W   = 5;

  // reset values
  localparam logic [7:0] RST_PATH_CTRL     = 8'h00;
  localparam logic [7:0] RST_OFFSET_LOW    = 8'h00;
  localparam logic [7:0] RST_OFFSET_HIGH   = 8'h00;
  localparam logic [5:0] RST_DIGITAL_GAIN  = 6'h20;
  localparam logic [5:0] RST_RISE_STEP     = 6'h01;
  localparam logic [5:0] RST_FALL_STEP     = 6'h01;
  localparam logic [2:0] RST_GATE_CTRL     = 3'h7;
  localparam logic [7:0] RST_SHUTDOWN_CTRL = 8'h8f;

  // last divider count: gain is stepped when the divider reaches this value, once every four converter clocks
  localparam logic [1:0] STEP_DIV_LAST = 2'h3;

  // gain ramp states
  typedef enum logic [1:0] {
    GS_OFF  = 2'b00,
    GS_RISE = 2'b01,
    GS_ON   = 2'b10,
    GS_FALL = 2'b11
  } gotr_ramp_type;

endpackage : gotr_pkg

//--- gotr_top.sv
`timescale 1ns/1ps
module gotr_top
  import gotr_pkg::*;
(
  // clock and reset
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst,
  // register access from the serial port
  input  wire logic [7:0]          i_reg_addr,
  input  wire logic [7:0]          i_reg_wdata,
  input  wire logic                i_reg_wr,
  input  wire logic                i_reg_rd,
  output logic      [7:0]          o_reg_rdata,
  // gate pin and sample buffer flags
  input  wire logic                i_transmit_gate_pin,
  input  wire logic                i_buffer_warning,
  input  wire logic                i_buffer_error,
  // sample stream
  input  wire logic [SAMPLE_W-1:0] i_sample,
  output logic      [SAMPLE_W-1:0] o_sample,
  // power and output state
  output logic                     o_output_on,
  output logic                     o_sleep,
  output logic                     o_power_down,
  output logic      [GAIN_W-1:0]   o_applied_gain
);

  // whole module state in one record
  typedef struct packed {
    logic                path_en;          // gain_offset_path_enable
    logic [7:0]          offset_low;       // dc_offset_low_byte
    logic [7:0]          offset_high;      // dc_offset_high_byte
    logic [GAIN_W-1:0]   gain_target;      // digital_gain_setting
    logic [GAIN_W-1:0]   rise_step;        // in units of 2^-4
    logic [GAIN_W-1:0]   fall_step;        // in units of 2^-4
    logic                ramp_en;          // gate_ramp_enable
    logic                sleep_en;         // gate_sleep_enable
    logic                pd_en;            // gate_powerdown_enable
    logic                cut_master;       // cutoff master enable
    logic                warn_cut_en;      // buffer_warning_cutoff_enable
    logic                err_cut_en;       // buffer_error_cutoff_enable
    logic                out_off;          // automatic shut-off is active
    gotr_ramp_type       ramp;             // ramp state
    logic [1:0]          div;              // four-clock step divider
    logic [GAIN_W-1:0]   gain;             // applied gain, units of 2^-5
    logic [SAMPLE_W-1:0] sample;           // output sample
    logic                sleep;            // sleep request
    logic                pd;               // power-down request
    logic [7:0]          rdata;            // read data
  } gotr_state_type;

  gotr_state_type st_r;   // registered state
  gotr_state_type st_nxt; // next state

  // combinational helpers
  logic                       run;        // output should be on
  logic                       cut_set;    // shut-off event this cycle
  logic                       restore;    // manual restore written
  logic                       tick;       // one gain step due
  logic [GAIN_W+1:0]          up_sum;     // gain plus rise step
  logic [GAIN_W:0]            up_inc;     // rise step in 2^-5 units
  logic [GAIN_W:0]            dn_dec;     // fall step in 2^-5 units
  logic signed [SAMPLE_W+7:0] product;    // sample times gain
  logic signed [SAMPLE_W+7:0] summed;     // scaled plus offset
  logic signed [SAMPLE_W+7:0] max_s;      // positive limit
  logic signed [SAMPLE_W+7:0] min_s;      // negative limit

  // next-state logic: register file, shut-off, ramp and datapath
  always_comb
  begin
    st_nxt  = st_r;
    restore = 1'b0;
    // register writes; unmapped addresses are ignored
    if (i_reg_wr)
    begin
      case (i_reg_addr)
        ADDR_PATH_CTRL:     st_nxt.path_en = i_reg_wdata[BIT_PATH_ENABLE];
        ADDR_OFFSET_LOW:    st_nxt.offset_low = i_reg_wdata;
        ADDR_OFFSET_HIGH:   st_nxt.offset_high = i_reg_wdata;
        ADDR_DIGITAL_GAIN:  st_nxt.gain_target = i_reg_wdata[GAIN_W-1:0];
        ADDR_RISE_STEP:     st_nxt.rise_step = i_reg_wdata[GAIN_W-1:0];
        ADDR_FALL_STEP:
        begin
          st_nxt.fall_step = i_reg_wdata[GAIN_W-1:0];
          restore          = i_reg_wdata[BIT_OUTPUT_RESTORE];
        end
        ADDR_GATE_CTRL:
        begin
          st_nxt.ramp_en  = i_reg_wdata[BIT_RAMP_ENABLE];
          st_nxt.sleep_en = i_reg_wdata[BIT_SLEEP_ENABLE];
          st_nxt.pd_en    = i_reg_wdata[BIT_POWERDOWN_ENABLE];
        end
        ADDR_SHUTDOWN_CTRL:
        begin
          st_nxt.cut_master  = i_reg_wdata[BIT_CUTOFF_MASTER];
          st_nxt.warn_cut_en = i_reg_wdata[BIT_WARNING_CUTOFF];
          st_nxt.err_cut_en  = i_reg_wdata[BIT_ERROR_CUTOFF];
        end
        default:
        begin
          // nothing stored
        end
      endcase
    end

    // shut-off flag: a buffer event in the restore cycle still wins
    cut_set = st_r.cut_master & ((st_r.warn_cut_en & i_buffer_warning)
                               | (st_r.err_cut_en & i_buffer_error));
    st_nxt.out_off = cut_set | (st_r.out_off & ~restore);

    // gate pin low or an active cut both drive the gain to zero
    run    = i_transmit_gate_pin & ~st_nxt.out_off;
    st_nxt.div = st_r.div + 2'h1;
    tick   = (st_r.div == STEP_DIV_LAST);
    // steps weigh 2^-4, applied gain weighs 2^-5, hence the shift
    up_inc = {st_r.rise_step, 1'b0};
    dn_dec = {st_r.fall_step, 1'b0};
    up_sum = {2'b00, st_r.gain} + {1'b0, up_inc};

    if (!st_r.ramp_en)
    begin
      // no ramp: gain switches in one step with the gate
      st_nxt.gain = run ? st_r.gain_target : '0;
      st_nxt.ramp = run ? GS_ON : GS_OFF;
    end
    else
    begin
      unique case (st_r.ramp)
        GS_OFF:
        begin
          st_nxt.gain = '0;
          if (run)
            st_nxt.ramp = GS_RISE;
        end
        GS_RISE:
        begin
          if (!run)
            st_nxt.ramp = GS_FALL;
          else if (tick)
          begin
            // clamp at the target so an odd step cannot overshoot
            if (up_sum >= {2'b00, st_r.gain_target})
            begin
              st_nxt.gain = st_r.gain_target;
              st_nxt.ramp = GS_ON;
            end
            else
              st_nxt.gain = up_sum[GAIN_W-1:0];
          end
        end
        GS_ON:
        begin
          // tracks a new target at once; only turning on and off (gate pin or shut-off) is ramped
          st_nxt.gain = st_r.gain_target;
          if (!run)
            st_nxt.ramp = GS_FALL;
        end
        GS_FALL:
        begin
          if (run)
            st_nxt.ramp = GS_RISE;
          else if (tick)
          begin
            if ({1'b0, st_r.gain} <= dn_dec)
            begin
              st_nxt.gain = '0;
              st_nxt.ramp = GS_OFF;
            end
            else
              st_nxt.gain = st_r.gain - dn_dec[GAIN_W-1:0];
          end
        end
      endcase
    end

    // low-power requests follow the gate pin directly
    st_nxt.sleep = st_r.sleep_en & ~i_transmit_gate_pin;
    st_nxt.pd    = st_r.pd_en & ~i_transmit_gate_pin;

    // datapath: gain first, then offset, then saturate
    // widen before the multiply so full gain times full scale cannot wrap
    product = ($signed({{8{i_sample[SAMPLE_W-1]}}, i_sample})
               * $signed({18'h00000, st_r.gain})) >>> FRAC_W;
    summed  = product + 24'($signed({st_r.offset_high, st_r.offset_low}));
    max_s   = 24'sh007fff;
    min_s   = -24'sh008000;
    if (!st_r.path_en)
      st_nxt.sample = i_sample;
    else if (summed > max_s)
      st_nxt.sample = 16'h7fff;
    else if (summed < min_s)
      st_nxt.sample = 16'h8000;
    else
      st_nxt.sample = summed[SAMPLE_W-1:0];

    // register reads; restore bit always reads back as zero
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        ADDR_PATH_CTRL:     st_nxt.rdata = 8'(st_r.path_en) << BIT_PATH_ENABLE;
        ADDR_OFFSET_LOW:    st_nxt.rdata = st_r.offset_low;
        ADDR_OFFSET_HIGH:   st_nxt.rdata = st_r.offset_high;
        ADDR_DIGITAL_GAIN:  st_nxt.rdata = {2'b00, st_r.gain_target};
        ADDR_RISE_STEP:     st_nxt.rdata = {2'b00, st_r.rise_step};
        ADDR_FALL_STEP:     st_nxt.rdata = {st_r.out_off, 1'b0, st_r.fall_step};
        ADDR_GATE_CTRL:     st_nxt.rdata = {5'h00, st_r.ramp_en, st_r.sleep_en, st_r.pd_en};
        ADDR_SHUTDOWN_CTRL: st_nxt.rdata = {st_r.cut_master, 3'h0, st_r.warn_cut_en,
                                            2'h0, st_r.err_cut_en};
        default:            st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // state register with reset values
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r.path_en     <= RST_PATH_CTRL[BIT_PATH_ENABLE];
      st_r.offset_low  <= RST_OFFSET_LOW;
      st_r.offset_high <= RST_OFFSET_HIGH;
      st_r.gain_target <= RST_DIGITAL_GAIN;
      st_r.rise_step   <= RST_RISE_STEP;
      st_r.fall_step   <= RST_FALL_STEP;
      st_r.ramp_en     <= RST_GATE_CTRL[BIT_RAMP_ENABLE];
      st_r.sleep_en    <= RST_GATE_CTRL[BIT_SLEEP_ENABLE];
      st_r.pd_en       <= RST_GATE_CTRL[BIT_POWERDOWN_ENABLE];
      st_r.cut_master  <= RST_SHUTDOWN_CTRL[BIT_CUTOFF_MASTER];
      st_r.warn_cut_en <= RST_SHUTDOWN_CTRL[BIT_WARNING_CUTOFF];
      st_r.err_cut_en  <= RST_SHUTDOWN_CTRL[BIT_ERROR_CUTOFF];
      st_r.out_off     <= 1'b0;
      st_r.ramp        <= GS_OFF;
      st_r.div         <= 2'h0;
      st_r.gain        <= '0;
      st_r.sample      <= '0;
      st_r.sleep       <= 1'b0;
      st_r.pd          <= 1'b0;
      st_r.rdata       <= 8'h00;
    end
    else
      st_r <= st_nxt;
  end

  // outputs straight from the state record
  assign o_reg_rdata    = st_r.rdata;
  assign o_sample       = st_r.sample;
  assign o_output_on    = ~st_r.out_off;
  assign o_sleep        = st_r.sleep;
  assign o_power_down   = st_r.pd;
  assign o_applied_gain = st_r.gain;

endmodule : gotr_top

//--- gotr_top_assertions.sv
`timescale 1ns/1ps
module gotr_top_checker
  import gotr_pkg::*;
(
  // clock and reset
  input wire logic                i_clk_sys,
  input wire logic                i_rst,
  // register port
  input wire logic [7:0]          i_reg_addr,
  input wire logic [7:0]          i_reg_wdata,
  input wire logic                i_reg_wr,
  // gate and buffer flags
  input wire logic                i_transmit_gate_pin,
  input wire logic                i_buffer_warning,
  input wire logic                i_buffer_error,
  // stream and state
  input wire logic [SAMPLE_W-1:0] i_sample,
  input wire logic [SAMPLE_W-1:0] o_sample,
  input wire logic                o_output_on,
  input wire logic                o_sleep,
  input wire logic                o_power_down,
  input wire logic [GAIN_W-1:0]   o_applied_gain
);
  logic [2:0] gate_r; // shadow of the gate control bits
  logic [7:0] cut_r;  // shadow of the shutdown control bits
  logic       path_r; // shadow of the path enable
  // event that must cut the output, set wins over restore
  wire        cause_w = cut_r[7] && ((cut_r[3] && i_buffer_warning)
                                     || (cut_r[0] && i_buffer_error));
  logic [1:0] step_ph; // mirror of the free-running four-clock step divider
  // divider runs from reset on every clock, so the mirror stays in phase
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      step_ph <= 2'h0;
    else
      step_ph <= step_ph + 2'h1;
  end
  // shadows follow writes so properties know the programmed modes
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      gate_r <= RST_GATE_CTRL;
      cut_r  <= RST_SHUTDOWN_CTRL;
      path_r <= 1'b0;
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == ADDR_GATE_CTRL) gate_r <= i_reg_wdata[2:0];
      if (i_reg_addr == ADDR_SHUTDOWN_CTRL) cut_r <= i_reg_wdata;
      if (i_reg_addr == ADDR_PATH_CTRL) path_r <= i_reg_wdata[BIT_PATH_ENABLE];
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  property p_sleep; !i_reg_wr && gate_r[1] && !i_transmit_gate_pin |=> o_sleep; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep request missing");
  property p_pd; !i_reg_wr && gate_r[0] && !i_transmit_gate_pin |=> o_power_down; endproperty
  a_pd: assert property (p_pd) else $error("power-down request missing");
  property p_awake; i_transmit_gate_pin |=> !o_sleep && !o_power_down; endproperty
  a_awake: assert property (p_awake) else $error("low power while gate high");
  property p_bypass; !i_reg_wr && !path_r |=> o_sample == $past(i_sample); endproperty
  a_bypass: assert property (p_bypass) else $error("sample altered while path off");
  property p_warn; !i_reg_wr && cut_r[7] && cut_r[3] && i_buffer_warning |=> !o_output_on; endproperty
  a_warn: assert property (p_warn) else $error("warning did not cut output");
  property p_err; !i_reg_wr && cut_r[7] && cut_r[0] && i_buffer_error |=> !o_output_on; endproperty
  a_err: assert property (p_err) else $error("error did not cut output");
  property p_master; !i_reg_wr && !cut_r[7] && o_output_on |=> o_output_on; endproperty
  a_master: assert property (p_master) else $error("cut with master off");
  property p_restore;
    i_reg_wr && i_reg_addr == ADDR_FALL_STEP && i_reg_wdata[BIT_OUTPUT_RESTORE] && !cause_w
      |=> o_output_on;
  endproperty
  a_restore: assert property (p_restore) else $error("restore did not turn output on");
  // with ramping on, gain moves only on the divider wrap; target writes excluded
  property p_step;
    !$past(i_reg_wr) && !$past(i_reg_wr, 2) && gate_r[2] && $changed(o_applied_gain)
      |-> step_ph == 2'h0;
  endproperty
  a_step: assert property (p_step) else $error("gain stepped too soon");
endmodule : gotr_top_checker

bind gotr_top gotr_top_checker u_gotr_top_checker (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
  .i_transmit_gate_pin(i_transmit_gate_pin), .i_buffer_warning(i_buffer_warning),
  .i_buffer_error(i_buffer_error), .i_sample(i_sample), .o_sample(o_sample),
  .o_output_on(o_output_on), .o_sleep(o_sleep), .o_power_down(o_power_down),
  .o_applied_gain(o_applied_gain)
);

//--- gotr_top_test.sv
`timescale 1ns/1ps
module gotr_top_test
  import gotr_pkg::*;
;
  logic        i_clk_sys = 1'b0, i_rst = 1'b1, wr = 1'b0, rd = 1'b0, gate = 1'b0;
  logic        warn_req = 1'b0, err_req = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic [15:0] osmp, x, off;
  logic [5:0]  gain, g;
  logic        on, slp, pd;
  wire  [15:0] smp;
  wire         warn, err;
  integer      failures = 0, n_checks = 0, seed = 72076, k;
  // reset table: addresses with their reset values, 0x40 is unmapped
  logic [7:0]  ra [9] = '{8'h27, 8'h3b, 8'h3c, 8'h3f, 8'h41, 8'h42, 8'h43, 8'h44, 8'h40};
  // shutdown control stores only bits 7, 3 and 0, so it reads back 0x89
  logic [7:0]  rv [9] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h01, 8'h01, 8'h07, 8'h89, 8'h00};
  always #50 i_clk_sys = ~i_clk_sys;
  gotr_top u_gotr_top (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_transmit_gate_pin(gate), .i_buffer_warning(warn), .i_buffer_error(err),
    .i_sample(smp), .o_sample(osmp), .o_output_on(on), .o_sleep(slp),
    .o_power_down(pd), .o_applied_gain(gain));
  gotr_buffer_model u_gotr_buffer_model (.i_clk_sys(i_clk_sys), .i_warn_req(warn_req),
    .i_err_req(err_req), .o_sample(smp), .o_warning(warn), .o_error(err));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  // one register access, strobe held for exactly one edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    {wr, rd, addr, wdata} = {w, !w, a, d};
    @(negedge i_clk_sys);
    {wr, rd} = 2'b00;
  endtask : acc
  // gain times sample, then offset, clamped instead of wrapping
  function automatic logic [15:0] model(logic [15:0] s, logic [5:0] m, logic [15:0] o);
    int p;
    p = (int'($signed(s)) * int'(m)) >>> 5;
    p = p + int'($signed(o));
    return p > 32767 ? 16'h7fff : (p < -32768 ? 16'h8000 : 16'(p));
  endfunction : model
  // follow a ramp to fin, each move by d and four clocks apart
  task automatic ramp(input logic [5:0] fin, input logic [5:0] d);
    logic [5:0] prev, want;
    int         last, t;
    prev = gain;
    last = -1;
    for (t = 0; t < 200 && prev !== fin; t++)
    begin
      @(negedge i_clk_sys);
      if (gain !== prev)
      begin
        want = fin > prev ? (prev + d > fin ? fin : prev + d) : (prev > d ? prev - d : 6'h00);
        chk(gain, want, "gain step");
        if (last >= 0) chk(16'(t - last), 16'h0004, "step spacing");
        last = t;
        prev = gain;
      end
    end
    chk(gain, fin, "ramp end");
  endtask : ramp
  task print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    failures++;
    print_verdict();
  end
  initial
  begin
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys) i_rst = 1'b0;
    acc(1'b1, 8'h40, 8'h5a);
    for (k = 0; k < 9; k++)
    begin
      acc(1'b0, ra[k], 8'h00);
      chk(rdata, rv[k], "reset value");
    end
    $display("test reset done");
    gate = 1'b1;
    ramp(6'h20, 6'h02);
    $display("test ramp up done");
    // corners first (full gain, offset at both limits), last pass with path off
    for (k = 0; k < 8; k++)
    begin
      g = k < 2 ? 6'h3f : 6'h02 + 6'($unsigned($random(seed)) % 62);
      off = k == 0 ? 16'h7fff : (k == 1 ? 16'h8000 : 16'($random(seed)));
      acc(1'b1, ADDR_DIGITAL_GAIN, {2'b00, g});
      acc(1'b1, ADDR_OFFSET_LOW, off[7:0]);
      acc(1'b1, ADDR_OFFSET_HIGH, off[15:8]);
      acc(1'b1, ADDR_PATH_CTRL, k < 7 ? 8'h20 : 8'h00);
      chk(gain, g, "gain tracks target");
      repeat (30)
      begin
        @(posedge i_clk_sys) x = smp;
        @(negedge i_clk_sys);
        chk(osmp, k < 7 ? model(x, g, off) : x, "sample");
      end
    end
    acc(1'b1, ADDR_DIGITAL_GAIN, 8'h20);
    $display("test datapath done");
    // warning cut, error cut, then warning with master off
    for (k = 0; k < 3; k++)
    begin
      acc(1'b1, ADDR_SHUTDOWN_CTRL, k == 2 ? 8'h09 : 8'h8f);
      @(negedge i_clk_sys) {warn_req, err_req} = k == 1 ? 2'b01 : 2'b10;
      @(negedge i_clk_sys) {warn_req, err_req} = 2'b00;
      chk(on, k == 2, "cutoff");
      acc(1'b0, ADDR_FALL_STEP, 8'h00);
      chk(rdata, k == 2 ? 8'h01 : 8'h81, "status bit");
      acc(1'b1, ADDR_FALL_STEP, 8'h41);
      chk(on, 1'b1, "restore");
      acc(1'b0, ADDR_FALL_STEP, 8'h00);
      chk(rdata, 8'h01, "restore self clear");
    end
    ramp(6'h20, 6'h02);
    $display("test shutdown done");
    acc(1'b1, ADDR_FALL_STEP, 8'h03);
    gate = 1'b0;
    ramp(6'h00, 6'h06);
    chk(slp, 1'b1, "sleep");
    chk(pd, 1'b1, "power-down");
    acc(1'b1, ADDR_GATE_CTRL, 8'h00);
    @(negedge i_clk_sys);
    chk({slp, pd}, 2'b00, "low power disabled");
    gate = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    chk(gain, 6'h20, "instant gain");
    $display("test gate modes done");
    print_verdict();
  end
endmodule : gotr_top_test
